//--- src/osf_pkg.sv
// constants, types and helpers shared by the serial output formatter
package osf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [6:0] ADDR_IFC_CFG   = 7'h20;
    localparam logic [6:0] ADDR_SYNC_CTRL = 7'h21;
    localparam logic [6:0] ADDR_SCRAMBLE  = 7'h22;
    localparam logic [6:0] ADDR_BYPASS    = 7'h24;
    localparam logic [6:0] ADDR_STATUS    = 7'h25;

    // field positions
    localparam int RES_LSB       = 0;
    localparam int LANE_LSB      = 2;
    localparam int REAL_BIT      = 4;
    localparam int SYNC_EN_BIT   = 0;
    localparam int SOFT_SYNC_BIT = 1;
    localparam int RELOAD_BIT    = 2;
    localparam int SCR_EN_BIT    = 6;
    localparam int BYPASS_BIT    = 2;
    localparam int SEEN_BIT      = 7;

    // values after reset
    localparam logic [7:0] IFC_CFG_RST   = 8'h02;
    localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
    localparam logic [7:0] SCRAMBLE_RST  = 8'h00;
    localparam logic [7:0] BYPASS_RST    = 8'h04;
    localparam logic [7:0] SOFT_SYNC_MSK = 8'h02;

    // counts
    localparam int         SPI_FRAME_BITS = 16;
    localparam logic [4:0] SPI_ADDR_LAST  = 5'h07;
    localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
    localparam logic [4:0] SPI_DATA_LAST  = 5'h0f;
    localparam int         DIV_BITS       = 6;
    localparam logic [5:0] DIV_LAST       = 6'h3f;
    localparam int         SCR_TAP_NEAR   = 14;
    localparam int         SCR_TAP_FAR    = 15;
    localparam int         LANES          = 2;
    localparam logic [5:0] WORD_MAX       = 6'h14;
    localparam logic [5:0] SHIFT_TOP      = 6'h27;

    typedef enum logic [1:0] {
        OSF_RES14 = 2'b00,
        OSF_RES16 = 2'b01,
        OSF_RES18 = 2'b10,
        OSF_RES20 = 2'b11
    } osf_res_t;

    typedef enum logic [1:0] {
        OSF_TWO_WIRE  = 2'b00,
        OSF_ONE_WIRE  = 2'b01,
        OSF_HALF_WIRE = 2'b10
    } osf_lane_t;

    function automatic logic [5:0] osf_res_bits(input logic [1:0] code);
        unique case (code)
            OSF_RES14: osf_res_bits = 6'h0e;
            OSF_RES16: osf_res_bits = 6'h10;
            OSF_RES18: osf_res_bits = 6'h12;
            default:   osf_res_bits = 6'h14;
        endcase
    endfunction

endpackage

//--- src/osf_reg_if.sv
// register access port between the serial control slave and the formatter
`timescale 1ns/1ps
interface osf_reg_if;
    logic       wrStrobe;
    logic [6:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;

    modport spi  (output wrStrobe, output addr, output wrData, input rdData);
    modport regs (input wrStrobe, input addr, input wrData, output rdData);
endinterface

//--- src/osf_spi_slave.sv
// serial control slave: 16-bit frames, read flag, 7-bit address, 8-bit data
`timescale 1ns/1ps
module osf_spi_slave (
    input  logic   core_clk,
    input  logic   rstN,
    input  logic   spiClk,
    input  logic   spiSelN,
    input  logic   spiDataIn,
    output logic   spiDataOut,
    output logic   spiDataOutEn,
    osf_reg_if.spi bus
);
    typedef struct packed {
        logic       clkS1, clkS2, clkPrev;
        logic       selS1, selS2;
        logic       dinS1, dinS2;
        logic [4:0] bitCnt;
        logic [15:0] shift;
        logic       isRead;
        logic [7:0] rdShift;
        logic       dout, doutEn;
        logic       wrStrobe;
        logic [6:0] addr;
        logic [7:0] wrData;
    } osf_spi_t;

    osf_spi_t s_reg, s_next;
    logic     rise, fall;

    // pins pass two flops before any edge detection
    assign rise = s_reg.clkS2 & ~s_reg.clkPrev;
    assign fall = ~s_reg.clkS2 & s_reg.clkPrev;

    always_comb begin
        s_next = s_reg;
        s_next.clkS1 = spiClk;
        s_next.clkS2 = s_reg.clkS1;
        s_next.clkPrev = s_reg.clkS2;
        s_next.selS1 = spiSelN;
        s_next.selS2 = s_reg.selS1;
        s_next.dinS1 = spiDataIn;
        s_next.dinS2 = s_reg.dinS1;
        s_next.wrStrobe = 1'b0;
        if (s_reg.selS2) begin
            s_next.bitCnt = 5'h00;
            s_next.doutEn = 1'b0;
        end else begin
            if (rise) begin
                s_next.shift = {s_reg.shift[14:0], s_reg.dinS2};
                s_next.bitCnt = s_reg.bitCnt + 5'h01;
                if (s_reg.bitCnt == osf_pkg::SPI_ADDR_LAST) begin
                    s_next.addr = {s_reg.shift[5:0], s_reg.dinS2};
                    s_next.isRead = s_reg.shift[6];
                end
                if (s_reg.bitCnt == osf_pkg::SPI_DATA_LAST && !s_reg.isRead) begin
                    s_next.wrStrobe = 1'b1;
                    s_next.wrData = {s_reg.shift[6:0], s_reg.dinS2};
                end
            end
            // read data leaves on falling edges so the master samples it on rising ones
            if (fall && s_reg.isRead && s_reg.bitCnt >= osf_pkg::SPI_DATA_FIRST && !s_reg.bitCnt[4]) begin
                s_next.doutEn = 1'b1;
                if (s_reg.bitCnt == osf_pkg::SPI_DATA_FIRST) begin
                    s_next.dout = bus.rdData[7];
                    s_next.rdShift = {bus.rdData[6:0], 1'b0};
                end else begin
                    s_next.dout = s_reg.rdShift[7];
                    s_next.rdShift = {s_reg.rdShift[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
            // select synchronisers start at the idle level so no false frame opens after reset
            s_reg.selS1 <= 1'b1;
            s_reg.selS2 <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.wrStrobe  = s_reg.wrStrobe;
    assign bus.addr      = s_reg.addr;
    assign bus.wrData    = s_reg.wrData;
    assign spiDataOut    = s_reg.dout;
    assign spiDataOutEn  = s_reg.doutEn;
endmodule // osf_spi_slave

//--- src/osf_lane_scrambler.sv
// one lane's self-synchronising scrambler with its own history of sent bits
`timescale 1ns/1ps
module osf_lane_scrambler (
    input  logic core_clk,
    input  logic rstN,
    input  logic bitIn,
    input  logic advance,
    input  logic enable,
    output logic bitOut
);
    typedef struct packed {
        logic [14:0] hist;
        logic        out;
    } osf_scr_t;

    osf_scr_t s_reg, s_next;
    logic     sent;

    // history holds transmitted bits, so the receiver can undo it from the line alone
    assign sent = bitIn ^ (enable & (s_reg.hist[osf_pkg::SCR_TAP_NEAR-1] ^ s_reg.hist[osf_pkg::SCR_TAP_FAR-1]));

    always_comb begin
        s_next = s_reg;
        if (advance) begin
            s_next.hist = {s_reg.hist[13:0], sent};
            s_next.out = sent;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bitOut = s_reg.out;

    AST_SCR_TAPS: assert property (@(posedge core_clk) disable iff (!rstN)
        advance && enable |=> bitOut == ($past(bitIn) ^ $past(s_reg.hist[13]) ^ $past(s_reg.hist[14])))
        else $error("scrambled bit does not match taps 14 and 15");
endmodule // osf_lane_scrambler

//--- src/osf_serial_formatter.sv
// serial output formatter: sync handling, word formatting, lane serialising
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - a register bit turns the shared pin from power-down into sync input
// - the sync pin is sampled on the rising clock edge
// - sync matters only with decimation; triggered by register write or pin; here a sync in bypass still restarts the frame
// - sync resets decimation dividers, aligns clocks and I/Q within one sample
// - sync resets oscillator phase and loads new frequency like the reload bit
// - complex: frame at Fs/N, lane at Fs*2R/L/N, data clock half lane rate
// - real: lane at Fs*R/L/M, frame Fs/M/2 on two lanes else Fs/M
// - two-wire, one-wire and half-wire lane modes set the lane bit rate
// - sample is formatted to 14, 16, 18 or 20 bits, 18 by default
// - truncate low bits; bypass 20-bit pads two zeros; decimation sends all 20
// - serialisation R/2, R or 2R per lane mode; data clock half lane rate
// - each lane has its own independent scrambler and history
// - scrambled bit k is XOR of bit k with sent bits k-14 and k-15
// - bit mapping follows scrambling in the output path; here there is no bit mapper and the scramblers drive the lanes directly
// - scrambling only when bypass is clear and scramble enable is set
// - new oscillator frequency waits for reload toggle or sync
module osf_serial_formatter (
    input  logic        core_clk,
    input  logic        resetn,
    input  logic        spiClk,
    input  logic        spiSelN,
    input  logic        spiDataIn,
    output logic        spiDataOut,
    output logic        spiDataOutEn,
    input  logic        powerdownSyncPin,
    input  logic [17:0] rawSample,
    input  logic [19:0] filtSampleI,
    input  logic [19:0] filtSampleQ,
    input  logic        sampleValid,
    output logic [1:0]  dataLanes,
    output logic        frameClock,
    output logic        forwardedDataClock,
    output logic        powerDown,
    output logic        dividerReset,
    output logic        ncoLoad,
    output logic [5:0]  decimPhase
);
    typedef struct packed {
        logic        pinS1, pinS2, pinPrev;
        logic [7:0]  cfgIfc, cfgSync, cfgScr, cfgBypass;
        logic        reloadPrev, syncSeen;
        logic [19:0] curI, curQ, prevI;
        logic [39:0] shiftReg;
        logic [7:0]  bitCnt;
        logic        halfPhase, frameClk, frameClkD, dataClk, dataClkD;
        logic [5:0]  divPhase;
        logic        divReset, ncoLd, powerDown;
    } osf_top_t;

    osf_top_t   s_reg, s_next;
    logic [1:0] rstPipe;
    logic       rstSyncN;
    osf_reg_if  regBus ();

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    osf_spi_slave u_spi (
        .core_clk     (core_clk),
        .rstN         (rstSyncN),
        .spiClk       (spiClk),
        .spiSelN      (spiSelN),
        .spiDataIn    (spiDataIn),
        .spiDataOut   (spiDataOut),
        .spiDataOutEn (spiDataOutEn),
        .bus          (regBus.spi)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoded settings
    logic        bypass, scrOn, realMode, twoWire, halfWire, realSingle;
    logic        softSync, pinSync, syncEvent, decimSync, reloadToggle, advance, frameEnd;
    logic [5:0]  resBits;
    logic [4:0]  padAmt;
    logic [6:0]  frameBits;
    logic [7:0]  frameLen;
    logic [19:0] resMask, firstFmt, secondFmt, padRaw;
    logic [39:0] word;
    logic [5:0]  lane0Idx;
    logic [1:0]  laneBit;
    logic [7:0]  cntNext;

    assign bypass     = s_reg.cfgBypass[osf_pkg::BYPASS_BIT];
    assign scrOn      = s_reg.cfgScr[osf_pkg::SCR_EN_BIT] & ~bypass;
    assign realMode   = bypass | s_reg.cfgIfc[osf_pkg::REAL_BIT];
    assign twoWire    = s_reg.cfgIfc[3:2] == osf_pkg::OSF_TWO_WIRE;
    assign halfWire   = s_reg.cfgIfc[3:2] == osf_pkg::OSF_HALF_WIRE;
    // one real sample per frame except on two lanes, where two samples share it
    assign realSingle = realMode & ~twoWire;
    assign resBits    = osf_pkg::osf_res_bits(s_reg.cfgIfc[1:0]);
    assign padAmt     = 5'(osf_pkg::WORD_MAX - resBits);
    assign resMask    = 20'hfffff << padAmt;
    // bypass carries the raw 18 bits with two zero lsbs; the filter supplies all 20
    assign padRaw     = {rawSample, 2'b00};
    assign firstFmt   = (realMode && twoWire ? s_reg.prevI : s_reg.curI) & resMask;
    assign secondFmt  = (realMode ? s_reg.curI : s_reg.curQ) & resMask;
    assign word       = realSingle ? {firstFmt, 20'h00000}
                                   : ({firstFmt, 20'h00000} | ({secondFmt, 20'h00000} >> resBits));
    assign frameBits  = realSingle ? {1'b0, resBits} : {resBits, 1'b0};

    always_comb begin
        unique case (s_reg.cfgIfc[3:2])
            osf_pkg::OSF_TWO_WIRE:  frameLen = {2'b00, frameBits[6:1]};
            // counted in lane bits; the halving of the rate comes from advance alone
            osf_pkg::OSF_HALF_WIRE: frameLen = {1'b0, frameBits};
            default:                frameLen = {1'b0, frameBits};
        endcase
    end

    // half-wire holds each bit two clocks, halving the lane rate
    assign advance  = ~halfWire | s_reg.halfPhase;
    assign frameEnd = advance && (s_reg.bitCnt == frameLen - 8'h01);
    assign lane0Idx = 6'(osf_pkg::SHIFT_TOP - frameLen[5:0]);
    // on two lanes lane1 starts the frame and lane0 carries its second half
    assign laneBit  = twoWire ? {s_reg.shiftReg[39], s_reg.shiftReg[lane0Idx]}
                              : {1'b0, s_reg.shiftReg[39]};

    ////////////////////////////////////////////////////////////////////////////
    // sync and reload
    assign softSync  = regBus.wrStrobe && regBus.addr == osf_pkg::ADDR_SYNC_CTRL
                       && regBus.wrData[osf_pkg::SOFT_SYNC_BIT];
    // pin edge only counts once the pin is switched to its sync role
    assign pinSync   = s_reg.cfgSync[osf_pkg::SYNC_EN_BIT] & s_reg.pinS2 & ~s_reg.pinPrev;
    assign syncEvent = softSync | pinSync;
    // dividers and oscillator only exist in the decimation path
    assign decimSync = syncEvent & ~bypass;
    assign reloadToggle = s_reg.reloadPrev != s_reg.cfgSync[osf_pkg::RELOAD_BIT];
    assign cntNext   = (frameEnd || syncEvent) ? 8'h00 : (advance ? s_reg.bitCnt + 8'h01 : s_reg.bitCnt);

    always_comb begin
        s_next = s_reg;
        s_next.pinS1 = powerdownSyncPin;
        s_next.pinS2 = s_reg.pinS1;
        s_next.pinPrev = s_reg.pinS2;
        s_next.reloadPrev = s_reg.cfgSync[osf_pkg::RELOAD_BIT];
        // register writes
        if (regBus.wrStrobe) begin
            unique case (regBus.addr)
                osf_pkg::ADDR_IFC_CFG:   s_next.cfgIfc = regBus.wrData;
                osf_pkg::ADDR_SYNC_CTRL: s_next.cfgSync = regBus.wrData & ~osf_pkg::SOFT_SYNC_MSK;
                osf_pkg::ADDR_SCRAMBLE:  s_next.cfgScr = regBus.wrData;
                osf_pkg::ADDR_BYPASS:    s_next.cfgBypass = regBus.wrData;
                osf_pkg::ADDR_STATUS:    s_next.syncSeen = s_reg.syncSeen & ~regBus.wrData[osf_pkg::SEEN_BIT];
                default:                 s_next.syncSeen = s_reg.syncSeen;
            endcase
        end
        // a sync in the same cycle as the clear still leaves the flag set
        if (syncEvent) begin
            s_next.syncSeen = 1'b1;
        end
        // power-down follows the pin unless the pin is in sync role
        s_next.powerDown = ~s_reg.cfgSync[osf_pkg::SYNC_EN_BIT] & s_reg.pinS2;
        // 64-phase divider; sync restarts it so several devices line up
        s_next.divPhase = decimSync ? 6'h00 : s_reg.divPhase + 6'h01;
        s_next.divReset = decimSync;
        s_next.ncoLd = decimSync | reloadToggle;
        // sample capture; the previous one feeds the two-lane real frame
        if (sampleValid) begin
            s_next.prevI = s_reg.curI;
            s_next.curI = bypass ? padRaw : filtSampleI;
            s_next.curQ = bypass ? 20'h00000 : filtSampleQ;
        end
        // serialiser
        s_next.halfPhase = halfWire ? ~s_reg.halfPhase : 1'b1;
        if (frameEnd || syncEvent) begin
            s_next.shiftReg = word;
        end else if (advance) begin
            s_next.shiftReg = {s_reg.shiftReg[38:0], 1'b0};
        end
        s_next.bitCnt = cntNext;
        if (syncEvent) begin
            s_next.halfPhase = 1'b0;
        end
        // high for the first half of each frame, so its rise marks the first bit
        s_next.frameClk = cntNext < {1'b0, frameLen[7:1]};
        s_next.frameClkD = s_reg.frameClk;
        s_next.dataClk = advance ? ~s_reg.dataClk : s_reg.dataClk;
        s_next.dataClkD = s_reg.dataClk;
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_reg <= '0;
            s_reg.cfgIfc <= osf_pkg::IFC_CFG_RST;
            s_reg.cfgSync <= osf_pkg::SYNC_CTRL_RST;
            s_reg.cfgScr <= osf_pkg::SCRAMBLE_RST;
            s_reg.cfgBypass <= osf_pkg::BYPASS_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read-back
    always_comb begin
        unique case (regBus.addr)
            osf_pkg::ADDR_IFC_CFG:   regBus.rdData = s_reg.cfgIfc;
            osf_pkg::ADDR_SYNC_CTRL: regBus.rdData = s_reg.cfgSync;
            osf_pkg::ADDR_SCRAMBLE:  regBus.rdData = s_reg.cfgScr;
            osf_pkg::ADDR_BYPASS:    regBus.rdData = s_reg.cfgBypass;
            osf_pkg::ADDR_STATUS:    regBus.rdData = {s_reg.syncSeen, 1'b0, s_reg.divPhase};
            default:                 regBus.rdData = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // lanes; the bit mapper, if any, sits after these scramblers
    generate
        for (genvar g = 0; g < osf_pkg::LANES; g++) begin : g_lane
            osf_lane_scrambler u_scr (
                .core_clk (core_clk),
                .rstN     (rstSyncN),
                .bitIn    (laneBit[g]),
                .advance  (advance),
                .enable   (scrOn),
                .bitOut   (dataLanes[g])
            );
        end
    endgenerate

    assign frameClock         = s_reg.frameClkD;
    assign forwardedDataClock = s_reg.dataClkD;
    assign powerDown          = s_reg.powerDown;
    assign dividerReset       = s_reg.divReset;
    assign ncoLoad            = s_reg.ncoLd;
    assign decimPhase         = s_reg.divPhase;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_PWRDN_PIN: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !s_reg.cfgSync[osf_pkg::SYNC_EN_BIT] ##1 !s_reg.cfgSync[osf_pkg::SYNC_EN_BIT] |-> powerDown == $past(s_reg.pinS2))
        else $error("power-down does not follow the pin");
    AST_SYNC_ROLE: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        s_reg.cfgSync[osf_pkg::SYNC_EN_BIT] && s_reg.pinS2 && !s_reg.pinPrev && !bypass |=> dividerReset && !powerDown)
        else $error("sync pin edge not taken");
    AST_DIV_RESET: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        decimSync |=> decimPhase == 6'h00 ##1 decimPhase == 6'h01)
        else $error("divider not restarted by sync");
    AST_DIV_WRAP: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !decimSync && s_reg.divPhase == osf_pkg::DIV_LAST |=> decimPhase == 6'h00 && !dividerReset)
        else $error("divider period is not 64");
    AST_NCO_SYNC: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        decimSync |=> ncoLoad)
        else $error("sync did not load the oscillator");
    AST_NCO_HOLD: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !decimSync && !reloadToggle |=> !ncoLoad)
        else $error("oscillator loaded without reload or sync");
    AST_FRAME_ALIGN: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        syncEvent |=> s_reg.bitCnt == 8'h00 && s_reg.shiftReg == $past(word) ##1 frameClock)
        else $error("sync did not restart the frame");
    AST_FORWARDED_DATA_CLOCK_HALF: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        advance |=> s_reg.dataClk != $past(s_reg.dataClk) ##1 forwardedDataClock == $past(s_reg.dataClk))
        else $error("data clock is not half the lane rate");
    AST_SCR_OFF: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !scrOn && advance |=> dataLanes == $past(laneBit))
        else $error("lane altered while scrambling is off");
endmodule // osf_serial_formatter

//--- verification/osf_rx_model.sv
// receiver model: lane0 and lane1 descramblers and frame capture
`timescale 1ns/1ps
module osf_rx_model (
    input  logic        core_clk,
    input  logic [1:0]  dataLanes,
    input  logic        frameClock,
    input  logic        descramble,
    output logic [39:0] lastWord,
    output logic [39:0] lastWord1,
    output int          frameCount
);
    logic [14:0] hist = 15'h0;
    logic [14:0] hist1 = 15'h0;
    logic [39:0] acc = 40'h0;
    logic [39:0] acc1 = 40'h0;
    logic        fcPrev = 1'b0;
    logic        rxBit;
    logic        rxBit1;
    assign rxBit1 = dataLanes[1] ^ (descramble & (hist1[13] ^ hist1[14]));
    // taps use received bits, so the model resyncs by itself after any error
    assign rxBit = dataLanes[0] ^ (descramble & (hist[13] ^ hist[14]));
    initial frameCount = 0;
    always @(posedge core_clk) begin
        hist   <= {hist[13:0], dataLanes[0]};
        hist1  <= {hist1[13:0], dataLanes[1]};
        fcPrev <= frameClock;
        if (frameClock && !fcPrev) begin
            lastWord   <= acc;
            lastWord1  <= acc1;
            acc        <= {39'h0, rxBit};
            acc1       <= {39'h0, rxBit1};
            frameCount <= frameCount + 1;
        end else begin
            acc  <= {acc[38:0], rxBit};
            acc1 <= {acc1[38:0], rxBit1};
        end
    end
endmodule // osf_rx_model

//--- verification/serial_output_sync_formatter_tb.sv
// self-checking bench for the serial output formatter
`timescale 1ns/1ps
module serial_output_sync_formatter_tb;
    logic core_clk = 0, resetn = 0, spiClk = 0, spiSelN = 1, spiDataIn = 0, pin = 0, sampleValid = 0, descr = 0;
    logic [17:0] raw = 18'h2d3a5;
    logic [19:0] fi = 20'h9c3e1, fq = 20'h4b7d2;
    logic [1:0]  dataLanes;
    logic        frameClock, powerDown, dividerReset, ncoLoad;
    logic [5:0]  decimPhase;
    logic [39:0] lastWord, lastWord1;
    logic [7:0]  q;
    logic        spiOut, spiOutEn, fwdClk, fwdPrev = 0;
    longint      tStart;
    int          dStart, dclkCount = 0;
    int          frameCount, fail_count = 0, checks_done = 0, ncoCount = 0, divCount = 0, sv = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        fwdPrev     <= fwdClk;
        dclkCount   <= dclkCount + int'(fwdClk !== fwdPrev);
        sv          <= (sv == 19) ? 0 : sv + 1;
        sampleValid <= (sv == 0);
        ncoCount    <= ncoCount + int'(ncoLoad === 1'b1);
        divCount    <= divCount + int'(dividerReset === 1'b1);
    end
    osf_serial_formatter u_dut (.core_clk(core_clk), .resetn(resetn), .spiClk(spiClk), .spiSelN(spiSelN),
        .spiDataIn(spiDataIn), .spiDataOut(spiOut), .spiDataOutEn(spiOutEn), .powerdownSyncPin(pin),
        .rawSample(raw), .filtSampleI(fi), .filtSampleQ(fq), .sampleValid(sampleValid), .dataLanes(dataLanes),
        .frameClock(frameClock), .forwardedDataClock(fwdClk), .powerDown(powerDown), .dividerReset(dividerReset),
        .ncoLoad(ncoLoad), .decimPhase(decimPhase));
    osf_rx_model u_rx (.core_clk(core_clk), .dataLanes(dataLanes), .frameClock(frameClock),
        .descramble(descr), .lastWord(lastWord), .lastWord1(lastWord1), .frameCount(frameCount));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // slow control clock: six core cycles per phase covers the input synchronisers
    task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {rd, a, d};
        @(posedge core_clk) spiSelN <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiDataIn <= f[i];
            repeat (6) @(posedge core_clk);
            if (i < 8) q[i] = spiOut;
            if (i < 8 && rd) chk(spiOutEn, 1'b1);
            spiClk <= 1'b1;
            repeat (6) @(posedge core_clk);
            spiClk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        spiSelN <= 1'b1;
        repeat (12) @(posedge core_clk);
    endtask
    task automatic frames(input int n);
        int start;
        start = frameCount;
        for (int i = 0; i < 600 && frameCount < start + n; i++) @(posedge core_clk);
        if (frameCount < start + n) begin
            fail_count++;
            end_of_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge core_clk);
        spi(1, 7'h20, 0); chk(q, 8'h02);
        spi(1, 7'h22, 0); chk(q, 8'h00);
        spi(1, 7'h24, 0); chk(q, 8'h04);
        spi(1, 7'h30, 0); chk(q, 8'h00);
        spi(0, 7'h22, 8'h40); spi(1, 7'h22, 0); chk(q, 8'h40);
        $display("registers done");
        // bypass stays set, so the scramble enable above must have no effect
        for (int r = 0; r < 4; r++) begin
            spi(0, 7'h20, 8'h04 | 8'(r));
            frames(3);
            chk(lastWord, 40'({raw, 2'b00} >> (6 - 2 * r)));
        end
        $display("formatting done");
        pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(powerDown, 1'b1);
        pin <= 1'b0;
        spi(0, 7'h24, 8'h00);
        spi(0, 7'h21, 8'h01);
        chk(powerDown, 1'b0);
        chk(divCount, 0);
        pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(divCount, 1);
        chk(ncoCount, 1);
        chk(decimPhase < 6'h0c, 1'b1);
        spi(1, 7'h25, 0); chk(q[7], 1'b1);
        spi(0, 7'h21, 8'h05); chk(ncoCount, 2);
        spi(0, 7'h21, 8'h03); chk(divCount, 2);
        pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        // pin edge reaches the divider three cycles on, exactly where it would wrap anyway
        for (int i = 0; i < 70 && decimPhase != 6'h3c; i++) @(posedge core_clk);
        pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(divCount, 3);
        chk(decimPhase, 6'h04);
        $display("sync done");
        descr <= 1'b1;
        spi(0, 7'h20, 8'h06);
        frames(3);
        chk(lastWord, {4'h0, fi[19:2], fq[19:2]});
        $display("scramble done");
        spi(0, 7'h20, 8'h02);
        frames(3);
        chk(lastWord1, 40'(fi[19:2]));
        chk(lastWord, 40'(fq[19:2]));
        spi(0, 7'h20, 8'h16);
        frames(3);
        chk(lastWord, 40'(fi[19:2]));
        spi(0, 7'h20, 8'h0a);
        frames(2);
        tStart = $time;
        dStart = dclkCount;
        frames(1);
        chk(40'(($time - tStart) / 10), 72);
        chk(dclkCount - dStart, 36);
        $display("lanes done");
        end_of_test();
    end
endmodule // serial_output_sync_formatter_tb
